// >>> design/pmcg_pkg.sv
// constants and types shared by both ends of the power-mode link
// assumes one 20 MHz clock and byte-wide registers on the device
package pmcg_pkg;

  // ***************************************************
  // device register offsets
  // ***************************************************
  localparam logic [7:0] CHIP_CONFIG_OFS = 8'h01;
  localparam logic [7:0] POWER_MODE_CONTROL_OFS = 8'hdf;
  localparam logic [7:0] MEMORY_SLEEP_OPTION_OFS = 8'he0;
  localparam logic [7:0] REFRESH_SETTING_OFS = 8'he1;

  // field positions
  localparam int PM_REQ_BIT = 7;
  localparam int CC_PLL_STABLE_BIT = 7;
  localparam int CC_XTAL_EN_BIT = 0;
  localparam int MSO_SELF_REFRESH_BIT = 7;
  localparam int STS_POWER_SAVE_BIT = 1;

  // values after reset
  localparam logic [7:0] PMC_RST = 8'h00;
  localparam logic [7:0] MSO_RST = 8'h00;
  localparam logic [7:0] REFRESH_RST = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int XTAL_START_NS = 1000;
  localparam int XTAL_START_CYCLES = (XTAL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************
  // modes, clock sources, states
  // ***************************************************
  typedef enum logic [1:0] {
    PMCG_MODE_NORMAL = 2'h0,
    PMCG_MODE_STANDBY = 2'h1,
    PMCG_MODE_SUSPEND = 2'h2,
    PMCG_MODE_SLEEP = 2'h3
  } pmcg_mode_t;

  typedef enum logic [1:0] {
    PMCG_SRC_STOP = 2'h0,
    PMCG_SRC_PLL = 2'h1,
    PMCG_SRC_OSC = 2'h2
  } pmcg_src_t;

  typedef enum logic [3:0] {
    DEV_NORMAL = 4'h1,
    DEV_PREP = 4'h2,
    DEV_SAVING = 4'h4,
    DEV_WAKE = 4'h8
  } pmcg_dev_state_t;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_ISSUE = 6'h02,
    H_ADDR = 6'h04,
    H_DATA = 6'h08,
    H_STAT = 6'h10,
    H_CAPT = 6'h20
  } pmcg_host_state_t;

  // ***************************************************
  // controller registers and sequence ops
  // ***************************************************
  localparam logic [3:0] HOST_CTRL_OFS = 4'h0;
  localparam logic [3:0] HOST_REFRESH_OFS = 4'h1;
  localparam logic [3:0] HOST_STATUS_OFS = 4'h2;
  localparam logic [3:0] HOST_IRQ_STATUS_OFS = 4'h3;
  localparam logic [3:0] HOST_IRQ_MASK_OFS = 4'h4;
  localparam int CTRL_MEM_OPT_BIT = 2;
  localparam int CTRL_GO_BIT = 7;
  localparam int IRQ_ENTERED_BIT = 0;
  localparam int IRQ_RESUMED_BIT = 1;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_POLL_STS = 2'h1,
    OP_POLL_CC = 2'h2,
    OP_END = 2'h3
  } pmcg_op_t;

endpackage

// >>> design/pmcg_if.sv
// register link between the power-mode controller and the device
// assumes both ends on one clock; read data follow one cycle later
`timescale 1ns/1ps
`default_nettype none
interface pmcg_if;
  logic bus_wr; // one-cycle write strobe
  logic bus_rd; // one-cycle read strobe
  logic bus_a0; // 0: address/status, 1: data
  logic [7:0] bus_wdata; // address or data byte
  logic [7:0] bus_rdata; // registered read answer

  modport device(input bus_wr, input bus_rd, input bus_a0, input bus_wdata, output bus_rdata);
  modport host(output bus_wr, output bus_rd, output bus_a0, output bus_wdata, input bus_rdata);
endinterface
`default_nettype wire

// >>> design/pmcg_timer.sv
// settle timer: counts while enabled, done once the count is reached
// assumes en drops between uses so the count restarts
`timescale 1ns/1ps
`default_nettype none
module pmcg_timer #(
  parameter int W = 16,
  parameter logic [W-1:0] CYCLES = 16'h0014
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic en,
  output logic done
);

  logic [W-1:0] cnt_r; // cycles spent enabled

  // ***************************************************
  // counter
  // ***************************************************
  // saturates at the target so done stays high while en holds
  always_ff @(posedge clk)
  begin
    if (rst || !en)
      cnt_r <= '0;
    else if (cnt_r != CYCLES)
      cnt_r <= cnt_r + 1'b1;
  end

  assign done = en && (cnt_r == CYCLES);

endmodule
`default_nettype wire

// >>> design/pmcg_device.sv
// device end: power-mode registers, mode sequencer, clock steering
// assumes the controller end drives the link and keeps its own duties
// Function
// - mode field 01 standby, 10 suspend, 11 sleep
// - normal: all PLLs on, clocks from PLLs
// - standby: pixel stops, memory PLL, core oscillator
// - suspend: PLLs off, memory oscillator, pixel stops
// - sleep: all stop, core oscillator if serial
// - sleep stops oscillator only with parallel host
// - write mode, then request bit starts entry
// - clearing request bit restores normal mode
// - status bit one shows power-saving state
// - sleep option: 0 power-down, 1 self-refresh
// - host programs refresh setting before suspend
// - host re-enables stopped oscillator on exit
// - chip config bit seven shows PLLs stable
// - panel interface silent while power-saving
// - host turns panel off before power-saving
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmcg_device import pmcg_pkg::*; #(
  parameter int XTAL_CYCLES = XTAL_START_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register link
  pmcg_if.device link,
  // straps and analog status
  input wire logic host_is_serial,
  input wire logic core_pll_locked,
  input wire logic memory_pll_locked,
  input wire logic pixel_pll_locked,
  // clock steering
  output pmcg_src_t core_clock_src,
  output pmcg_src_t memory_clock_src,
  output logic pixel_clock_en,
  output logic core_pll_en,
  output logic memory_pll_en,
  output logic pixel_pll_en,
  output logic crystal_source_en,
  // display memory and panel
  output logic mem_self_refresh,
  output logic mem_power_down,
  output logic [7:0] refresh_setting,
  output logic panel_active
);

  // ***************************************************
  // declarations
  // ***************************************************
  logic [7:0] addr_r; // register pointer from address cycle
  logic [7:0] pmc_r; // mode field and request bit
  logic [7:0] mso_r; // memory sleep option
  logic [7:0] refresh_r; // memory refresh setting
  logic [7:0] rdata_r; // registered read answer
  logic xtal_run_r; // oscillator running
  pmcg_mode_t pm_mode; // mode field as written
  pmcg_mode_t active_mode_r; // mode latched at entry
  logic active_opt_r; // sleep option latched at entry
  pmcg_dev_state_t state_r;
  pmcg_dev_state_t state_nxt;
  logic req; // request bit
  logic data_wr; // data write cycle
  logic stop_xtal; // prep cycle with parallel host, in any mode
  logic xtal_wr; // host writes the oscillator enable
  logic wake_ok; // oscillator settled during wake
  logic pll_on; // PLL enable, next state
  logic all_locked; // every PLL reports lock
  logic pll_stable; // PLLs on and locked
  logic saving_nxt; // power-saving as seen in status
  pmcg_src_t core_nxt;
  pmcg_src_t mem_nxt;

  assign pm_mode = pmcg_mode_t'(pmc_r[1:0]);
  assign req = pmc_r[PM_REQ_BIT];
  assign data_wr = link.bus_wr && link.bus_a0;
  assign all_locked = core_pll_locked && memory_pll_locked && pixel_pll_locked;
  assign pll_stable = core_pll_en && all_locked;
  assign xtal_wr = data_wr && (addr_r == CHIP_CONFIG_OFS) && link.bus_wdata[CC_XTAL_EN_BIT];
  assign stop_xtal = (state_r == DEV_PREP) && !host_is_serial;

  // ***************************************************
  // register writes
  // ***************************************************
  // address cycle loads the pointer used by data cycles
  always_ff @(posedge clk)
  begin
    if (rst)
      addr_r <= 8'h00;
    else if (link.bus_wr && !link.bus_a0)
      addr_r <= link.bus_wdata;
  end

  // mode control: field first, request bit after it
  always_ff @(posedge clk)
  begin
    if (rst)
      pmc_r <= PMC_RST;
    else if (data_wr && (addr_r == POWER_MODE_CONTROL_OFS))
      pmc_r <= link.bus_wdata;
  end

  // memory sleep option and refresh setting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mso_r <= MSO_RST;
      refresh_r <= REFRESH_RST;
    end
    else if (data_wr && (addr_r == MEMORY_SLEEP_OPTION_OFS))
      mso_r <= link.bus_wdata;
    else if (data_wr && (addr_r == REFRESH_SETTING_OFS))
      refresh_r <= link.bus_wdata;
  end

  // oscillator run flag; the host's enable write beats a same-cycle stop
  always_ff @(posedge clk)
  begin
    if (rst)
      xtal_run_r <= 1'b1;
    else if (xtal_wr)
      xtal_run_r <= 1'b1;
    else if (stop_xtal && (active_mode_r == PMCG_MODE_SLEEP))
      xtal_run_r <= 1'b0;
  end

  // ***************************************************
  // register reads
  // ***************************************************
  // status read when a0 is low, pointed register when high
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (link.bus_rd && !link.bus_a0)
      rdata_r <= 8'(saving_nxt) << STS_POWER_SAVE_BIT;
    else if (link.bus_rd)
    begin
      case (addr_r)
        CHIP_CONFIG_OFS:
          rdata_r <= (8'(pll_stable) << CC_PLL_STABLE_BIT)
                   | (8'(xtal_run_r) << CC_XTAL_EN_BIT);
        POWER_MODE_CONTROL_OFS: rdata_r <= pmc_r;
        MEMORY_SLEEP_OPTION_OFS: rdata_r <= mso_r;
        REFRESH_SETTING_OFS: rdata_r <= refresh_r;
        default: rdata_r <= 8'h00; // unmapped reads as zero
      endcase
    end
  end

  assign link.bus_rdata = rdata_r;

  // ***************************************************
  // mode sequencer
  // ***************************************************
  // oscillator startup wait before PLLs are restarted
  pmcg_timer #(
    .W(16),
    .CYCLES(16'(XTAL_CYCLES))
  ) u_xtal_timer (
    .clk(clk),
    .rst(rst),
    .en((state_r == DEV_WAKE) && xtal_run_r),
    .done(wake_ok)
  );

  // next state; a request with mode normal is ignored
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DEV_NORMAL:
        if (req && (pm_mode != PMCG_MODE_NORMAL))
          state_nxt = DEV_PREP;
      DEV_PREP:
        state_nxt = DEV_SAVING;
      DEV_SAVING:
        if (!req)
          state_nxt = DEV_WAKE;
      DEV_WAKE:
        if (wake_ok && pll_stable)
          state_nxt = DEV_NORMAL;
      default:
        state_nxt = DEV_NORMAL;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= DEV_NORMAL;
    else
      state_r <= state_nxt;
  end

  // mode and sleep option are frozen for the whole excursion
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_mode_r <= PMCG_MODE_NORMAL;
      active_opt_r <= 1'b0;
    end
    else if ((state_r == DEV_NORMAL) && (state_nxt == DEV_PREP))
    begin
      active_mode_r <= pm_mode;
      active_opt_r <= mso_r[MSO_SELF_REFRESH_BIT];
    end
  end

  // status shows saving from prep until wake has finished
  assign saving_nxt = (state_r != DEV_NORMAL);

  // ***************************************************
  // clock steering, next values
  // ***************************************************
  // prep keeps normal clocks; memory parking and the new clocks both start in the first saving cycle
  always_comb
  begin
    core_nxt = PMCG_SRC_PLL;
    mem_nxt = PMCG_SRC_PLL;
    pll_on = 1'b1;
    if ((state_nxt == DEV_SAVING) || (state_nxt == DEV_WAKE))
    begin
      case (active_mode_r)
        PMCG_MODE_STANDBY:
        begin
          core_nxt = PMCG_SRC_OSC;
          mem_nxt = PMCG_SRC_PLL;
        end
        PMCG_MODE_SUSPEND:
        begin
          pll_on = 1'b0;
          mem_nxt = PMCG_SRC_OSC;
          core_nxt = host_is_serial ? PMCG_SRC_OSC : PMCG_SRC_STOP;
        end
        PMCG_MODE_SLEEP:
        begin
          pll_on = 1'b0;
          mem_nxt = PMCG_SRC_STOP;
          core_nxt = host_is_serial ? PMCG_SRC_OSC : PMCG_SRC_STOP;
        end
        default:
        begin
          core_nxt = PMCG_SRC_PLL;
          mem_nxt = PMCG_SRC_PLL;
        end
      endcase
      // wake brings the PLLs up once the oscillator has settled
      if ((state_nxt == DEV_WAKE) && wake_ok)
        pll_on = 1'b1;
    end
  end

  // ***************************************************
  // registered outputs
  // ***************************************************
  // clock sources and PLL enables
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_clock_src <= PMCG_SRC_PLL;
      memory_clock_src <= PMCG_SRC_PLL;
      core_pll_en <= 1'b1;
      memory_pll_en <= 1'b1;
      pixel_pll_en <= 1'b1;
    end
    else
    begin
      core_clock_src <= core_nxt;
      memory_clock_src <= mem_nxt;
      core_pll_en <= pll_on;
      memory_pll_en <= pll_on;
      pixel_pll_en <= pll_on;
    end
  end

  // pixel clock and panel only in normal
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pixel_clock_en <= 1'b1;
      panel_active <= 1'b1;
    end
    else
    begin
      pixel_clock_en <= (state_nxt == DEV_NORMAL);
      panel_active <= (state_nxt == DEV_NORMAL);
    end
  end

  // memory parking held from the first saving cycle of a sleep until normal
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_self_refresh <= 1'b0;
      mem_power_down <= 1'b0;
    end
    else
    begin
      mem_self_refresh <= (state_r != DEV_NORMAL) && (state_nxt != DEV_NORMAL)
                        && (active_mode_r == PMCG_MODE_SLEEP) && active_opt_r;
      mem_power_down <= (state_r != DEV_NORMAL) && (state_nxt != DEV_NORMAL)
                      && (active_mode_r == PMCG_MODE_SLEEP) && !active_opt_r;
    end
  end

  assign crystal_source_en = xtal_run_r;
  assign refresh_setting = refresh_r;

endmodule
`default_nettype wire

// >>> design/pmcg_host.sv
// controller end: runs entry and exit sequences over the link
// assumes software orders through a plain register port
`timescale 1ns/1ps
`default_nettype none
module pmcg_host import pmcg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq,
  // panel control
  output logic panel_off,
  // register link
  pmcg_if.host link
);

  // ***************************************************
  // declarations
  // ***************************************************
  logic [1:0] mode_r; // requested mode
  logic opt_r; // memory sleep option
  logic [7:0] refresh_r; // refresh setting to program
  logic [1:0] irq_sts_r; // sticky events
  logic [1:0] irq_mask_r; // event enables
  logic saving_r; // device believed in power-saving
  logic exit_r; // running the exit sequence
  logic [2:0] step_r; // sequence step
  logic [17:0] op_r; // kind, address, data
  pmcg_op_t kind;
  logic [17:0] op_nxt; // op of the current step, looked up now
  pmcg_op_t kind_nxt; // kind of the current step's op
  pmcg_host_state_t state_r;
  logic go; // start request from software
  logic match; // poll answer as hoped
  logic done_ev; // sequence finished
  logic [1:0] irq_set;

  assign kind = pmcg_op_t'(op_r[17:16]);
  assign go = sw_wr && (sw_addr == HOST_CTRL_OFS) && sw_wdata[CTRL_GO_BIT] && (state_r == H_IDLE)
            && (saving_r || (sw_wdata[1:0] != 2'h0));
  assign done_ev = (state_r == H_ISSUE) && (kind_nxt == OP_END);

  // ***************************************************
  // sequence table
  // ***************************************************
  // exit polls power state, then PLL stability, before normal use
  function automatic logic [17:0] host_op(input logic ex, input logic [2:0] st,
                                         input logic [1:0] md, input logic op,
                                         input logic [7:0] rf);
    logic [7:0] mb;
    mb = {6'h00, md};
    host_op = {OP_END, 8'h00, 8'h00};
    if (!ex)
    begin
      case (st)
        3'h0: host_op = {OP_WRITE, REFRESH_SETTING_OFS, rf};
        3'h1: host_op = {OP_WRITE, MEMORY_SLEEP_OPTION_OFS, 8'(op) << MSO_SELF_REFRESH_BIT};
        3'h2: host_op = {OP_WRITE, POWER_MODE_CONTROL_OFS, mb};
        3'h3: host_op = {OP_WRITE, POWER_MODE_CONTROL_OFS, mb | (8'h01 << PM_REQ_BIT)};
        3'h4: host_op = {OP_POLL_STS, 8'h00, 8'h00};
        default: host_op = {OP_END, 8'h00, 8'h00};
      endcase
    end
    else
    begin
      case (st)
        3'h0: host_op = {OP_WRITE, POWER_MODE_CONTROL_OFS, mb};
        3'h1: host_op = {OP_WRITE, CHIP_CONFIG_OFS, 8'h01 << CC_XTAL_EN_BIT};
        3'h2: host_op = {OP_POLL_STS, 8'h00, 8'h00};
        3'h3: host_op = {OP_POLL_CC, CHIP_CONFIG_OFS, 8'h00};
        default: host_op = {OP_END, 8'h00, 8'h00};
      endcase
    end
  endfunction

  // issue decides on the fresh op; a stale one would replay the last poll forever
  assign op_nxt = host_op(exit_r, step_r, mode_r, opt_r, refresh_r);
  assign kind_nxt = pmcg_op_t'(op_nxt[17:16]);

  // ***************************************************
  // link sequencer
  // ***************************************************
  assign match = (kind == OP_POLL_STS) ? (link.bus_rdata[STS_POWER_SAVE_BIT] == !exit_r)
                                       : link.bus_rdata[CC_PLL_STABLE_BIT];

  // a write is address then data; polls repeat until matched
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= H_IDLE;
      step_r <= 3'h0;
      op_r <= 18'h00000;
    end
    else
    begin
      case (state_r)
        H_IDLE:
          if (go)
          begin
            state_r <= H_ISSUE;
            step_r <= 3'h0;
          end
        H_ISSUE:
        begin
          op_r <= op_nxt;
          state_r <= H_ADDR;
          if (kind_nxt == OP_END)
            state_r <= H_IDLE;
          else if (kind_nxt == OP_POLL_STS)
            state_r <= H_STAT;
        end
        H_ADDR:
          state_r <= H_DATA;
        H_DATA:
          state_r <= (kind == OP_WRITE) ? H_ISSUE : H_CAPT;
        H_STAT:
          state_r <= H_CAPT;
        H_CAPT:
          if (match)
            state_r <= H_ISSUE;
          else
            state_r <= (kind == OP_POLL_STS) ? H_STAT : H_ADDR;
        default:
          state_r <= H_IDLE;
      endcase
      // step advances as a write or a matched poll completes
      if (((state_r == H_DATA) && (kind == OP_WRITE)) || ((state_r == H_CAPT) && match))
        step_r <= step_r + 3'h1;
    end
  end

  // strobes follow the op latched in the last issue cycle
  assign link.bus_wr = (state_r == H_ADDR) || ((state_r == H_DATA) && (kind == OP_WRITE));
  assign link.bus_rd = (state_r == H_STAT) || ((state_r == H_DATA) && (kind != OP_WRITE));
  assign link.bus_a0 = (state_r == H_DATA);
  assign link.bus_wdata = (state_r == H_ADDR) ? op_r[15:8] : op_r[7:0];

  // ***************************************************
  // direction, panel and software registers
  // ***************************************************
  // panel goes off before the first link write of an entry
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exit_r <= 1'b0;
      saving_r <= 1'b0;
      panel_off <= 1'b0;
    end
    else if (go)
    begin
      exit_r <= saving_r;
      if (!saving_r)
        panel_off <= 1'b1;
    end
    else if (done_ev)
    begin
      saving_r <= !exit_r;
      if (exit_r)
        panel_off <= 1'b0;
    end
  end

  // control and refresh setting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_r <= 2'h0;
      opt_r <= 1'b0;
      refresh_r <= 8'h00;
      irq_mask_r <= 2'h0;
    end
    else if (sw_wr)
    begin
      case (sw_addr)
        HOST_CTRL_OFS:
        begin
          mode_r <= sw_wdata[1:0];
          opt_r <= sw_wdata[CTRL_MEM_OPT_BIT];
        end
        HOST_REFRESH_OFS: refresh_r <= sw_wdata;
        HOST_IRQ_MASK_OFS: irq_mask_r <= sw_wdata[1:0];
        default: refresh_r <= refresh_r;
      endcase
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign irq_set = {done_ev && exit_r, done_ev && !exit_r};
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_sts_r <= 2'h0;
    else if (sw_wr && (sw_addr == HOST_IRQ_STATUS_OFS))
      irq_sts_r <= (irq_sts_r & ~sw_wdata[1:0]) | irq_set;
    else
      irq_sts_r <= irq_sts_r | irq_set;
  end

  assign irq = |(irq_sts_r & irq_mask_r);

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst || !sw_rd)
      sw_rdata <= 8'h00;
    else
    begin
      case (sw_addr)
        HOST_CTRL_OFS: sw_rdata <= {5'h00, opt_r, mode_r};
        HOST_REFRESH_OFS: sw_rdata <= refresh_r;
        HOST_STATUS_OFS: sw_rdata <= {5'h00, panel_off, saving_r, state_r != H_IDLE};
        HOST_IRQ_STATUS_OFS: sw_rdata <= {6'h00, irq_sts_r};
        HOST_IRQ_MASK_OFS: sw_rdata <= {6'h00, irq_mask_r};
        default: sw_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> dv/pmcg_asserts.sv
// checker: link strobes and device clock steering
// assumes one clock domain with a sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module pmcg_asserts import pmcg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link and device outputs
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic host_is_serial,
  input wire pmcg_src_t core_clock_src,
  input wire pmcg_src_t memory_clock_src,
  input wire logic pixel_clock_en,
  input wire logic core_pll_en,
  input wire logic memory_pll_en,
  input wire logic pixel_pll_en,
  input wire logic crystal_source_en,
  input wire logic panel_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_EXCL: assert property (!(bus_wr && bus_rd)) else $error("both strobes high");
  AST_PLLS: assert property (core_pll_en == memory_pll_en && memory_pll_en == pixel_pll_en)
    else $error("pll enables differ");
  AST_NORMAL: assert property (panel_active |-> core_clock_src == PMCG_SRC_PLL
    && memory_clock_src == PMCG_SRC_PLL && pixel_clock_en) else $error("normal clocks wrong");
  AST_PANEL: assert property (core_clock_src != PMCG_SRC_PLL |-> !panel_active && !pixel_clock_en)
    else $error("panel or pixel active");
  AST_STBY: assert property (memory_clock_src == PMCG_SRC_PLL && core_clock_src == PMCG_SRC_OSC
    |-> core_pll_en) else $error("standby plls off");
  AST_SUSP: assert property (memory_clock_src == PMCG_SRC_OSC |-> !pixel_clock_en &&
    core_clock_src == (host_is_serial ? PMCG_SRC_OSC : PMCG_SRC_STOP)) else $error("suspend clocks");
  AST_SLEEP: assert property (memory_clock_src == PMCG_SRC_STOP |->
    core_clock_src == (host_is_serial ? PMCG_SRC_OSC : PMCG_SRC_STOP)) else $error("sleep core");
  AST_PLL_OFF: assert property ($fell(core_pll_en) |-> memory_clock_src != PMCG_SRC_PLL)
    else $error("pll off with pll clock");
  AST_XTAL: assert property (!crystal_source_en |-> !host_is_serial && !core_pll_en)
    else $error("oscillator stopped wrongly");
endmodule
`default_nettype wire

// >>> dv/power_mode_clock_gating_bench.sv
// bench: both ends joined by the link, driven through the software port
// assumes a 20 MHz clock and plls that lock at once, except during the suspend exit test
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_gating_bench import pmcg_pkg::*;;
  logic clk, rst, ser, lock, sw_wr, sw_rd, irq, panel_off;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, rv, refresh_setting;
  pmcg_src_t core_clock_src, memory_clock_src;
  logic pixel_clock_en, core_pll_en, memory_pll_en, pixel_pll_en, crystal_source_en;
  logic mem_self_refresh, mem_power_down, panel_active;
  int mismatches, n_tests;
  pmcg_if pmcg_if_i();
  // short oscillator start keeps the run brief
  pmcg_device #(.XTAL_CYCLES(2)) pmcg_device_i(.clk(clk), .rst(rst), .link(pmcg_if_i),
    .host_is_serial(ser), .core_pll_locked(lock), .memory_pll_locked(lock),
    .pixel_pll_locked(lock), .core_clock_src(core_clock_src),
    .memory_clock_src(memory_clock_src), .pixel_clock_en(pixel_clock_en),
    .core_pll_en(core_pll_en), .memory_pll_en(memory_pll_en), .pixel_pll_en(pixel_pll_en),
    .crystal_source_en(crystal_source_en), .mem_self_refresh(mem_self_refresh),
    .mem_power_down(mem_power_down), .refresh_setting(refresh_setting),
    .panel_active(panel_active));
  pmcg_host pmcg_host_i(.clk(clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .panel_off(panel_off),
    .link(pmcg_if_i));
  pmcg_asserts pmcg_asserts_i(.clk(clk), .rst(rst), .bus_wr(pmcg_if_i.bus_wr),
    .bus_rd(pmcg_if_i.bus_rd), .host_is_serial(ser), .core_clock_src(core_clock_src),
    .memory_clock_src(memory_clock_src), .pixel_clock_en(pixel_clock_en),
    .core_pll_en(core_pll_en), .memory_pll_en(memory_pll_en), .pixel_pll_en(pixel_pll_en),
    .crystal_source_en(crystal_source_en), .panel_active(panel_active));
  // ************
  // tasks
  // ************
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    rv = sw_rdata;
  endtask
  task wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(8'(irq), 8'h01);
  endtask
  // one entry and exit through a power-saving mode
  task run(input logic [1:0] m, input logic opt);
    pmcg_src_t cs, ms;
    cs = (m == 2'h1 || ser) ? PMCG_SRC_OSC : PMCG_SRC_STOP;
    ms = (m == 2'h1) ? PMCG_SRC_PLL : (m == 2'h2) ? PMCG_SRC_OSC : PMCG_SRC_STOP;
    wr(HOST_REFRESH_OFS, {6'h14, m});
    wr(HOST_IRQ_STATUS_OFS, 8'hff);
    wr(HOST_CTRL_OFS, {1'b1, 4'h0, opt, m});
    wait_irq;
    rd(HOST_STATUS_OFS);
    chk(rv & 8'h06, 8'h06);
    chk(8'(core_clock_src), 8'(cs));
    chk(8'(memory_clock_src), 8'(ms));
    chk(8'({pixel_clock_en, panel_active, core_pll_en, pixel_pll_en}), 8'({2'h0, {2{m == 2'h1}}}));
    chk(8'({mem_self_refresh, mem_power_down, crystal_source_en}),
      8'({m == 2'h3 && opt, m == 2'h3 && !opt, m != 2'h3 || ser}));
    chk(refresh_setting, {6'h14, m});
    wr(HOST_IRQ_STATUS_OFS, 8'h01);
    // suspend exit with unlocked plls must stall short of normal
    lock <= (m != 2'h2);
    wr(HOST_CTRL_OFS, 8'h80);
    repeat (40) @(posedge clk);
    #1;
    chk(8'({panel_active, irq}), (m == 2'h2) ? 8'h00 : 8'h03);
    rd(HOST_STATUS_OFS);
    chk(rv & 8'h03, (m == 2'h2) ? 8'h03 : 8'h00);
    lock <= 1'b1;
    wait_irq;
    rd(HOST_STATUS_OFS);
    chk(rv & 8'h06, 8'h00);
    chk(8'({core_clock_src, memory_clock_src}), 8'h05);
    chk(8'({pixel_clock_en, panel_active, crystal_source_en}), 8'h07);
    $display("test mode %0d serial %0d done", m, ser);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ************
  // clock, watchdog, tests
  // ************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial
  begin
    {rst, ser, lock, sw_addr, sw_wdata, sw_wr, sw_rd} = {1'b1, 1'b0, 1'b1, 4'h0, 8'h00, 2'h0};
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr(HOST_IRQ_MASK_OFS, 8'h03);
    wr(HOST_CTRL_OFS, 8'h80);
    repeat (10) @(posedge clk);
    rd(HOST_STATUS_OFS);
    chk(rv & 8'h02, 8'h00);
    rd(4'hf);
    chk(rv, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      ser <= s[0];
      for (int m = 1; m < 4; m++)
        run(m[1:0], s[0]);
    end
    wr(HOST_IRQ_MASK_OFS, 8'h01);
    chk(8'(irq), 8'h00);
    wr(HOST_IRQ_MASK_OFS, 8'h03);
    chk(8'(irq), 8'h01);
    wr(HOST_IRQ_STATUS_OFS, 8'h02);
    chk(8'(irq), 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
